// *** rtl/fault_cfg.svh ***
`ifndef FAULT_CFG_SVH
`define FAULT_CFG_SVH

// Register indices, byte address is four times the index.
`define IDX_UV_RESP 10'h05a
`define IDX_OC_LIMIT 10'h05b
`define IDX_PAGE 10'h000
`define IDX_CTRL 10'h001
`define IDX_STATUS 10'h002
`define IDX_MASK 10'h003
`define IDX_UV_LIMIT 10'h004
`define IDX_OUT_STATE 10'h005

// Field positions of the undervoltage response byte.
`define UV_BEHAV_MSB 7
`define UV_BEHAV_LSB 6
`define UV_RETRY_MSB 5
`define UV_RETRY_LSB 3
`define UV_DELAY_MSB 2
`define UV_DELAY_LSB 0

// Reset values.
`define RST_UV_RESP 8'h84
`define RST_OC_LIMIT 16'h1388
`define RST_UV_LIMIT 16'h0000
`define RST_CTRL 8'h00

// Timing.
`define CLK_MHZ 250
`define RETRY_UNIT_MS 25
`define RETRY_UNIT_CYC (`RETRY_UNIT_MS * 1000 * `CLK_MHZ)

`endif

// *** rtl/fault_detect.sv ***
`timescale 1ns/10ps
`include "fault_cfg.svh"
module fault_detect
  import fault_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [15:0] vin_reading,
  input wire logic [15:0] iin_reading,
  input wire limits_t limits,
  output logic uv_fault_q,
  output logic oc_fault_q
);

  logic [16:0] uv_clear_level;

  // The clear level sits one sixteenth of the threshold above it, so a noisy input cannot chatter the fault.
  assign uv_clear_level = {1'b0, limits.uv_limit} + {5'h00, limits.uv_limit[15:4]};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      uv_fault_q <= 1'b0;
    end else if (ce) begin
      if (vin_reading < limits.uv_limit) begin
        uv_fault_q <= 1'b1;
      end else if ({1'b0, vin_reading} > uv_clear_level) begin
        uv_fault_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      oc_fault_q <= 1'b0;
    end else if (ce) begin
      oc_fault_q <= $signed(iin_reading) > $signed(limits.oc_limit);
    end
  end

  chk_uv_hold_hyst: assert property (@(posedge clk_sys) disable iff (rst)
    ce && uv_fault_q && ({1'b0, vin_reading} <= uv_clear_level) |=> uv_fault_q)
    else $error("undervoltage fault cleared inside the hysteresis band");

  chk_oc_signed_cmp: assert property (@(posedge clk_sys) disable iff (rst)
    ce |=> oc_fault_q == ($signed($past(iin_reading)) > $signed($past(limits.oc_limit))))
    else $error("overcurrent flag disagrees with signed compare");

endmodule : fault_detect

// *** rtl/fault_pkg.sv ***
package fault_pkg;

  typedef enum logic [1:0] {
    BEHAV_CONTINUE = 2'h0,
    BEHAV_RSVD_1 = 2'h1,
    BEHAV_DISABLE = 2'h2,
    BEHAV_RSVD_3 = 2'h3
  } uv_behav_t;

  typedef struct packed {
    uv_behav_t behav;
    logic [2:0] retry;
    logic [2:0] delay;
  } uv_resp_t;

  typedef enum logic [2:0] {
    RETRY_NONE = 3'h0,
    RETRY_FOREVER = 3'h7
  } retry_code_t;

  typedef struct packed {
    logic [15:0] uv_limit;
    logic [15:0] oc_limit;
  } limits_t;

  typedef enum {
    ST_OFF,
    ST_RUN,
    ST_LATCH,
    ST_WAIT
  } resp_state_t;

endpackage : fault_pkg

// *** rtl/input_fault_response_config.sv ***
`timescale 1ns/10ps
`include "fault_cfg.svh"
// Notes on behaviour
// - An undervoltage fault clears only after the input rises above threshold plus one sixteenth of it.
// - Response bits 7:6 decode 00 as continue, 10 as disable and retry, 01 and 11 unsupported.
// - An undervoltage fault pulls the alert line low and sets its status flag.
// - Retry code 000 keeps the output off until restarted; 001 to 110 are unsupported.
// - Retry code 111 restarts without limit.
// - Retrying stops on command off, bias loss or another shutting fault.
// - The wait between restarts comes from delay bits 2:0.
// - Delay code 0 is no wait, 1 to 6 are 25 ms per count, 7 is 175 ms.
// - The undervoltage response is one byte, readable and writable.
// - The sixteen bit overcurrent limit is the threshold for the input current reading.
// - The limit is signed two's complement in 10 mA steps.
// - The limit covers the whole signed sixteen bit range.
module input_fault_response_config
  import fault_pkg::*;
#(
  parameter int NUM_PAGES = 2,
  parameter int RETRY_UNIT_CYC = `RETRY_UNIT_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [15:0] vin_reading,
  input wire logic [15:0] iin_reading,
  input wire logic control_pin_on,
  input wire logic bias_ok,
  input wire logic [NUM_PAGES-1:0] other_fault,
  output logic [NUM_PAGES-1:0] out_enable,
  output logic fault_alert_line_n,
  output logic irq
);

  localparam int PAGE_W = (NUM_PAGES > 1) ? $clog2(NUM_PAGES) : 1;
  localparam int ST_W = 2 * NUM_PAGES;

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage.

  uv_resp_t uv_resp_q [NUM_PAGES];
  limits_t limits_q [NUM_PAGES];
  logic [PAGE_W-1:0] page_q;
  logic [NUM_PAGES-1:0] op_on_q;
  logic [ST_W-1:0] status_q;
  logic [ST_W-1:0] mask_q;
  logic [ST_W-1:0] status_set;
  logic [ST_W-1:0] status_clr;
  logic [NUM_PAGES-1:0] uv_fault;
  logic [NUM_PAGES-1:0] oc_fault;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave. Zero wait state: read data are prepared in the address phase.

  logic wr_pend_q;
  logic [9:0] wr_idx_q;
  logic addr_ok;
  logic [9:0] a_idx;
  logic [31:0] rdata_d;
  logic [31:0] wdata;

  assign addr_ok = hsel && htrans[1] && hready;
  assign a_idx = haddr[11:2];
  assign wdata = hwdata;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 10'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (ce) begin
      wr_pend_q <= addr_ok && hwrite;
      if (addr_ok) wr_idx_q <= a_idx;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // A read that directly follows a write to the same word sees the old value.
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (a_idx)
      `IDX_UV_RESP: rdata_d[7:0] = uv_resp_q[page_q];
      `IDX_OC_LIMIT: rdata_d[15:0] = limits_q[page_q].oc_limit;
      `IDX_UV_LIMIT: rdata_d[15:0] = limits_q[page_q].uv_limit;
      `IDX_PAGE: rdata_d[PAGE_W-1:0] = page_q;
      `IDX_CTRL: rdata_d[NUM_PAGES-1:0] = op_on_q;
      `IDX_STATUS: rdata_d[ST_W-1:0] = status_q;
      `IDX_MASK: rdata_d[ST_W-1:0] = mask_q;
      `IDX_OUT_STATE: rdata_d[NUM_PAGES-1:0] = out_enable;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (ce && addr_ok && !hwrite) begin
      hrdata <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Paged configuration.

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int p = 0; p < NUM_PAGES; p++) begin
        uv_resp_q[p] <= `RST_UV_RESP;
        limits_q[p].oc_limit <= `RST_OC_LIMIT;
        limits_q[p].uv_limit <= `RST_UV_LIMIT;
      end
    end else if (ce && wr_pend_q) begin
      unique case (wr_idx_q)
        `IDX_UV_RESP: uv_resp_q[page_q] <= wdata[7:0];
        `IDX_OC_LIMIT: limits_q[page_q].oc_limit <= wdata[15:0];
        `IDX_UV_LIMIT: limits_q[page_q].uv_limit <= wdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      page_q <= '0;
      op_on_q <= NUM_PAGES'(`RST_CTRL);
      mask_q <= '1;
    end else if (ce && wr_pend_q) begin
      unique case (wr_idx_q)
        `IDX_PAGE: page_q <= wdata[PAGE_W-1:0];
        `IDX_CTRL: op_on_q <= wdata[NUM_PAGES-1:0];
        `IDX_MASK: mask_q <= wdata[ST_W-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per page fault detection and response.

  for (genvar p = 0; p < NUM_PAGES; p++) begin : g_page
    fault_detect u_detect (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .vin_reading(vin_reading),
      .iin_reading(iin_reading),
      .limits(limits_q[p]),
      .uv_fault_q(uv_fault[p]),
      .oc_fault_q(oc_fault[p])
    );

    retry_ctrl #(
      .UNIT_CYC(RETRY_UNIT_CYC)
    ) u_retry (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .run_req(control_pin_on && op_on_q[p] && bias_ok),
      .other_fault(other_fault[p]),
      .uv_fault(uv_fault[p]),
      .cfg(uv_resp_q[p]),
      .out_en_q(out_enable[p])
    );

    assign status_set[2*p] = uv_fault[p];
    assign status_set[2*p+1] = oc_fault[p];

    chk_page_uv_flag: assert property (@(posedge clk_sys) disable iff (rst)
      ce && uv_fault[p] |=> status_q[2*p])
      else $error("page undervoltage fault did not set its status bit");

    chk_page_oc_flag: assert property (@(posedge clk_sys) disable iff (rst)
      ce && oc_fault[p] |=> status_q[2*p+1])
      else $error("page overcurrent fault did not set its status bit");

    chk_page_stop_off: assert property (@(posedge clk_sys) disable iff (rst)
      ce && (other_fault[p] || !op_on_q[p]) |=> !out_enable[p])
      else $error("page output enabled while its stop condition held");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status, mask and alert. A fault present in the clearing cycle keeps its bit.

  assign status_clr = (wr_pend_q && wr_idx_q == `IDX_STATUS) ? wdata[ST_W-1:0] : '0;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_q <= '0;
    end else if (ce) begin
      status_q <= (status_q & ~status_clr) | status_set;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fault_alert_line_n <= 1'b1;
      irq <= 1'b0;
    end else if (ce) begin
      fault_alert_line_n <= !(|(status_q & mask_q));
      irq <= |(status_q & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_write_uv(logic [7:0] v);
    ce && addr_ok && hwrite && a_idx == `IDX_UV_RESP ##1 ce && wdata[7:0] == v;
  endsequence

  chk_uv_byte_rw: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 s_write_uv(hwdata[7:0]) |=> uv_resp_q[page_q] == $past(wdata[7:0]))
    else $error("undervoltage response byte not stored");

  chk_uv_sets_flag: assert property (@(posedge clk_sys) disable iff (rst)
    ce && uv_fault[0] |=> status_q[0])
    else $error("undervoltage fault did not set its status bit");

  chk_alert_follows: assert property (@(posedge clk_sys) disable iff (rst)
    ce && (|(status_q & mask_q)) |=> !fault_alert_line_n && irq)
    else $error("alert line not low for unmasked fault");

  chk_page_select: assert property (@(posedge clk_sys) disable iff (rst)
    ce && addr_ok && !hwrite && a_idx == `IDX_OC_LIMIT |=>
      hrdata[15:0] == $past(limits_q[page_q].oc_limit) && hrdata[31:16] == 16'h0000)
    else $error("paged limit read returned wrong copy");

  sequence s_addr_write;
    ce && addr_ok && hwrite;
  endsequence

  sequence s_addr_read;
    ce && addr_ok && !hwrite;
  endsequence

  sequence s_data_write(logic [9:0] idx);
    ce && wr_pend_q && wr_idx_q == idx;
  endsequence

  // The slave never inserts wait states, so a master can rely on one cycle per phase.
  chk_bus_okay: assert property (@(posedge clk_sys) disable iff (rst)
    hreadyout && !hresp)
    else $error("bus slave stalled or returned an error");

  chk_write_pending: assert property (@(posedge clk_sys) disable iff (rst)
    s_addr_write |=> wr_pend_q && wr_idx_q == $past(a_idx))
    else $error("write address phase not carried into the data phase");

  chk_rdata_holds: assert property (@(posedge clk_sys) disable iff (rst)
    !(ce && addr_ok && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");

  chk_uv_read_paged: assert property (@(posedge clk_sys) disable iff (rst)
    s_addr_read ##0 (a_idx == `IDX_UV_RESP) |=> hrdata == {24'h00_0000, $past(uv_resp_q[page_q])})
    else $error("undervoltage response read returned wrong copy");

  chk_unmapped_zero: assert property (@(posedge clk_sys) disable iff (rst)
    s_addr_read ##0 (a_idx > `IDX_OC_LIMIT) |=> hrdata == 32'h0000_0000)
    else $error("unmapped read returned nonzero data");

  chk_oc_limit_store: assert property (@(posedge clk_sys) disable iff (rst)
    s_data_write(`IDX_OC_LIMIT) |=> limits_q[page_q].oc_limit == $past(wdata[15:0]))
    else $error("overcurrent limit not stored in the selected page");

  chk_uv_limit_store: assert property (@(posedge clk_sys) disable iff (rst)
    s_data_write(`IDX_UV_LIMIT) |=> limits_q[page_q].uv_limit == $past(wdata[15:0]))
    else $error("undervoltage limit not stored in the selected page");

  chk_mask_store: assert property (@(posedge clk_sys) disable iff (rst)
    s_data_write(`IDX_MASK) |=> mask_q == $past(wdata[ST_W-1:0]))
    else $error("mask write not stored");

  chk_ctrl_store: assert property (@(posedge clk_sys) disable iff (rst)
    s_data_write(`IDX_CTRL) |=> op_on_q == $past(wdata[NUM_PAGES-1:0]))
    else $error("operation control write not stored");

  chk_page_store: assert property (@(posedge clk_sys) disable iff (rst)
    s_data_write(`IDX_PAGE) |=> page_q == $past(wdata[PAGE_W-1:0]))
    else $error("page select write not stored");

  chk_status_w1c: assert property (@(posedge clk_sys) disable iff (rst)
    s_data_write(`IDX_STATUS) |=> (status_q & $past(wdata[ST_W-1:0] & ~status_set)) == '0)
    else $error("status bit survived a clear with no event");

  chk_set_wins: assert property (@(posedge clk_sys) disable iff (rst)
    ce |=> (status_q & $past(status_set)) == $past(status_set))
    else $error("fault event lost against a status clear");

  chk_masked_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    ce && (status_q & mask_q) == '0 |=> fault_alert_line_n && !irq)
    else $error("alert raised with no unmasked status bit");

  chk_alert_pair: assert property (@(posedge clk_sys) disable iff (rst)
    fault_alert_line_n == !irq)
    else $error("alert line and interrupt disagree");

endmodule : input_fault_response_config

// *** rtl/retry_ctrl.sv ***
`timescale 1ns/10ps
`include "fault_cfg.svh"
module retry_ctrl
  import fault_pkg::*;
#(
  parameter int UNIT_CYC = `RETRY_UNIT_CYC,
  parameter int CNT_W = 26
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic run_req,
  input wire logic other_fault,
  input wire logic uv_fault,
  input wire uv_resp_t cfg,
  output logic out_en_q
);

  resp_state_t state_q;
  resp_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic stop;
  logic trip;

  assign stop = !run_req || other_fault;
  // Unsupported behaviour codes act as continue; unsupported retry codes act as no retry.
  assign trip = uv_fault && (cfg.behav == BEHAV_DISABLE);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_OFF: begin
        if (!stop) state_d = ST_RUN;
      end
      ST_RUN: begin
        if (stop) state_d = ST_OFF;
        else if (trip) state_d = (cfg.retry == RETRY_FOREVER) ? ST_WAIT : ST_LATCH;
      end
      ST_LATCH: begin
        if (!run_req) state_d = ST_OFF;
      end
      ST_WAIT: begin
        if (stop) state_d = ST_OFF;
        else if (cnt_q == '0) state_d = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= ST_OFF;
      out_en_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      out_en_q <= (state_d == ST_RUN);
    end
  end

  // A zero delay code restarts at once, which may hammer a weak input supply.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (state_d == ST_WAIT && state_q != ST_WAIT) begin
        cnt_q <= CNT_W'(32'(cfg.delay) * UNIT_CYC);
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  sequence s_trip_disable;
    ce && state_q == ST_RUN && !stop && trip;
  endsequence

  chk_trip_disables: assert property (@(posedge clk_sys) disable iff (rst)
    s_trip_disable |=> !out_en_q)
    else $error("output stayed enabled after undervoltage trip");

  chk_latch_holds: assert property (@(posedge clk_sys) disable iff (rst)
    ce && state_q == ST_LATCH && run_req |=> state_q == ST_LATCH && !out_en_q)
    else $error("latched output restarted without a restart");

  chk_delay_load: assert property (@(posedge clk_sys) disable iff (rst)
    s_trip_disable and (cfg.retry == RETRY_FOREVER) |=>
      cnt_q == CNT_W'(32'(cfg.delay) * UNIT_CYC))
    else $error("retry delay loaded with wrong count");

  chk_retry_restart: assert property (@(posedge clk_sys) disable iff (rst)
    ce && state_q == ST_WAIT && cnt_q == '0 && !stop |=> state_q == ST_RUN ##0 out_en_q)
    else $error("retry did not restart after delay");

  chk_stop_retry: assert property (@(posedge clk_sys) disable iff (rst)
    ce && stop |=> state_q == ST_OFF || state_q == ST_LATCH)
    else $error("retrying continued after stop condition");

endmodule : retry_ctrl

// *** tb/ahb_host_model.sv ***
`timescale 1ns/10ps
// Bus host: single word transfers only, idle between them.
module ahb_host_model (
  input wire logic clk_sys,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic [1:0] htrans,
  output logic [31:0] haddr,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic [31:0] rd_val,
  output logic rd_done,
  output logic hang
);
  initial begin
    htrans = 2'h0;
    haddr = 32'h0000_0000;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    rd_val = 32'h0000_0000;
    rd_done = 1'b0;
    hang = 1'b0;
  end

  // A stalled slave must not hang the run, so the wait is bounded.
  task wait_rdy;
    int n;
    n = 0;
    @(posedge clk_sys);
    while (hready !== 1'b1 && n < 64) begin
      n++;
      @(posedge clk_sys);
    end
    if (n == 64) hang <= 1'b1;
  endtask : wait_rdy

  task xfer(input logic wr, input logic [9:0] idx, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {20'h0_0000, idx, 2'b00};
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd_val <= hrdata;
    rd_done <= !wr;
    hwdata <= ~d;
    @(posedge clk_sys);
    rd_done <= 1'b0;
  endtask : xfer
endmodule : ahb_host_model

// *** tb/input_fault_response_config_test.sv ***
`timescale 1ns/10ps
`include "fault_cfg.svh"
module input_fault_response_config_test;
  import fault_pkg::*;
  localparam int UNIT = 4;
  logic clk_sys, rst, pin_on, hwrite, hreadyout, hresp, rd_done, hang, alert_n, irq, bias_ok, stuck;
  logic [1:0] htrans, other_fault, out_enable;
  logic [2:0] hsize;
  logic [15:0] vin, iin;
  logic [31:0] haddr, hwdata, hrdata, rd_val, r;
  logic [31:0] exp_q[$];
  logic [7:0] codes[3];
  int fail_count, n_checks, seed, lo;

  input_fault_response_config #(.NUM_PAGES(2), .RETRY_UNIT_CYC(UNIT)) dut (
    .clk_sys(clk_sys), .rst(rst), .ce(1'b1), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .vin_reading(vin), .iin_reading(iin),
    .control_pin_on(pin_on), .bias_ok(bias_ok), .other_fault(other_fault),
    .out_enable(out_enable), .fault_alert_line_n(alert_n), .irq(irq));

  ahb_host_model host (
    .clk_sys(clk_sys), .hready(hreadyout), .hrdata(hrdata), .htrans(htrans), .haddr(haddr),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .rd_val(rd_val), .rd_done(rd_done),
    .hang(hang));

  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : check

  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task wr(input logic [9:0] idx, input logic [31:0] d);
    host.xfer(1'b1, idx, d);
  endtask : wr

  task rd(input logic [9:0] idx, input logic [31:0] e);
    exp_q.push_back(e);
    host.xfer(1'b0, idx, 32'h0000_0000);
  endtask : rd

  // One cycle below the limit, then well above the clearing level.
  task uv_pulse;
    vin <= 16'h00ff;
    @(posedge clk_sys);
    vin <= 16'h0200;
  endtask : uv_pulse

  task off_time(output int n);
    int w;
    w = 0;
    n = 0;
    while (out_enable[0] !== 1'b0 && w < 9) begin
      w++;
      @(posedge clk_sys);
    end
    while (out_enable[0] === 1'b0 && n < 99) begin
      n++;
      @(posedge clk_sys);
    end
    if (w == 9 || n == 99) stuck = 1'b1;
  endtask : off_time

  always @(posedge clk_sys) begin
    if (rd_done === 1'b1)
      check(rd_val, exp_q.pop_front());
    if (hang === 1'b1 || stuck === 1'b1) begin
      fail_count++;
      complete_run();
    end
  end

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h9d30;
    rst = 1'b1;
    pin_on = 1'b0;
    bias_ok = 1'b1;
    stuck = 1'b0;
    other_fault = 2'h0;
    vin = 16'h0200;
    iin = 16'h8000;
    codes = '{8'h3f, 8'h7f, 8'hff};
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    rd(`IDX_UV_RESP, 32'h0000_0084);
    rd(`IDX_OC_LIMIT, 32'h0000_1388);
    rd(10'h3ff, 32'h0000_0000);
    r = $random(seed);
    wr(`IDX_PAGE, 32'h0000_0001);
    wr(`IDX_UV_RESP, {24'h00_0000, r[7:0]});
    rd(`IDX_UV_RESP, {24'h00_0000, r[7:0]});
    wr(`IDX_PAGE, 32'h0000_0000);
    rd(`IDX_UV_RESP, 32'h0000_0084);
    wr(`IDX_OC_LIMIT, 32'h0000_fff6);
    iin <= 16'hfff6;
    repeat (3) @(posedge clk_sys);
    wr(`IDX_STATUS, 32'h0000_000f);
    rd(`IDX_STATUS, 32'h0000_0000);
    iin <= 16'hfff7;
    repeat (4) @(posedge clk_sys);
    rd(`IDX_STATUS, 32'h0000_0002);
    iin <= 16'h8000;
    wr(`IDX_STATUS, 32'h0000_0002);
    rd(`IDX_STATUS, 32'h0000_0000);
    wr(`IDX_UV_LIMIT, 32'h0000_0100);
    vin <= 16'h00ff;
    repeat (4) @(posedge clk_sys);
    check(alert_n, 32'h0);
    check(irq, 32'h1);
    rd(`IDX_STATUS, 32'h0000_0001);
    vin <= 16'h0110;
    wr(`IDX_STATUS, 32'h0000_0001);
    rd(`IDX_STATUS, 32'h0000_0001);
    vin <= 16'h0111;
    wr(`IDX_STATUS, 32'h0000_0001);
    rd(`IDX_STATUS, 32'h0000_0000);
    check(irq, 32'h0);
    wr(`IDX_MASK, 32'h0000_0000);
    uv_pulse();
    repeat (4) @(posedge clk_sys);
    check(irq, 32'h0);
    wr(`IDX_MASK, 32'h0000_000f);
    repeat (3) @(posedge clk_sys);
    check(irq, 32'h1);
    wr(`IDX_STATUS, 32'h0000_0001);
    wr(`IDX_CTRL, 32'h0000_0001);
    pin_on <= 1'b1;
    repeat (5) @(posedge clk_sys);
    check(out_enable[0], 32'h1);
    // Default setting latches off until the enable is cycled.
    uv_pulse();
    repeat (40) @(posedge clk_sys);
    check(out_enable[0], 32'h0);
    pin_on <= 1'b0;
    repeat (3) @(posedge clk_sys);
    pin_on <= 1'b1;
    repeat (5) @(posedge clk_sys);
    check(out_enable[0], 32'h1);
    for (int d = 1; d < 8; d += 6) begin
      wr(`IDX_UV_RESP, {24'h00_0000, 5'h17, d[2:0]});
      repeat (2) begin
        uv_pulse();
        off_time(lo);
        check({31'h0, lo >= d * UNIT && lo <= d * UNIT + 3}, 32'h1);
      end
    end
    foreach (codes[i]) begin
      wr(`IDX_UV_RESP, {24'h00_0000, codes[i]});
      uv_pulse();
      repeat (8) begin
        @(posedge clk_sys);
        check(out_enable[0], 32'h1);
      end
    end
    // Other fault, bias loss and pin off each land inside a pending retry wait; the output must not pulse on.
    wr(`IDX_UV_RESP, 32'h0000_00bf);
    for (int k = 0; k < 3; k++) begin
      uv_pulse();
      repeat (4) @(posedge clk_sys);
      if (k == 0) other_fault <= 2'h1;
      if (k == 1) bias_ok <= 1'b0;
      if (k == 2) pin_on <= 1'b0;
      repeat (40) begin
        @(posedge clk_sys);
        check(out_enable[0], 32'h0);
      end
      other_fault <= 2'h0;
      bias_ok <= 1'b1;
      pin_on <= 1'b1;
      repeat (5) @(posedge clk_sys);
      check(out_enable[0], 32'h1);
    end
    check(out_enable[1], 32'h0);
    check(hresp, 32'h0);
    rd(`IDX_OUT_STATE, 32'h0000_0001);
    repeat (2) @(posedge clk_sys);
    complete_run();
  end
endmodule : input_fault_response_config_test
